// ---- core/csm_port.sv ----
// Purpose: device end; holds config and local management words per function
// Assumes: requester holds request steady until done
// Notes:   storage is a modelled array indexed by space, function and register
`timescale 1ns/1ps
// Summary of operation
// - 19-bit dword address selects one register
// - address bits 17:10 select the function
// - address bits 9:0 select the register
// - bit 18 picks config or local space
// - write strobe writes 32-bit data
// - byte enables gate each written byte
// - read strobe requests a read
// - read returns addressed register contents
// - done pulses exactly one cycle
// - root port override writes read-only type-1 fields
// - override ignored in endpoint or non-type-1
module csm_port
    import csm_pkg::*;
#(
    parameter int  FUNCS     = 4,
    parameter int  REGS      = 16,
    parameter bit  ROOT_PORT = 1'b1
) (
    input  wire logic clock,
    input  wire logic rst,
    csm_if.port       bus
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {
        CSM_IDLE = 2'b00,
        CSM_DONE = 2'b01,
        CSM_WAIT = 2'b10
    } csm_state_t;
    typedef struct packed {
        csm_state_t        st;
        logic [DATA_W-1:0] rdata;
        logic              done;
    } csm_ctl_t;
    csm_ctl_t q, d;
    // memory kept out of the struct to keep it an array
    logic [DATA_W-1:0] mem_q [2][FUNCS][REGS];
    logic              sp;
    logic [FUNC_W-1:0] fn;
    logic [REG_W-1:0]  rg;
    logic              hit;
    logic              is_t1;
    logic [DATA_W-1:0] wmask;
    logic [DATA_W-1:0] cur;
    logic              do_wr;
    logic [DATA_W-1:0] be_mask;
    // ****************************************
    // byte lanes
    // ****************************************
    for (genvar b = 0; b < BE_W; b++) begin : g_be
        assign be_mask[b*8 +: 8] = {8{bus.byte_enable[b]}};
    end
    // ****************************************
    // decode
    // ****************************************
    always_comb begin
        sp  = bus.addr[SPACE_BIT];
        fn  = bus.addr[FUNC_HI:FUNC_LO];
        rg  = bus.addr[REG_HI:REG_LO];
        hit = (32'(fn) < FUNCS) && (32'(rg) < REGS);
        cur = hit ? mem_q[sp][fn[1:0]][rg[3:0]] : DATA_RST;
        // only type-1 words carry protected bits; every other word is fully writable
        is_t1 = !sp && rg >= T1_REG_FIRST && rg <= T1_REG_LAST;
        // override honoured only in root port mode, so endpoint keeps the bits fixed
        if (is_t1 && !(ROOT_PORT && bus.type1_readonly_override)) begin
            wmask = ~T1_RO_MASK;
        end else begin
            wmask = '1;
        end
        wmask = wmask & be_mask;
        do_wr = 1'b0;
        d      = q;
        d.done = 1'b0;
        unique case (q.st)
            CSM_IDLE: begin
                if (bus.write || bus.read) begin
                    do_wr   = bus.write && !bus.read && hit;
                    d.rdata = bus.read ? cur : q.rdata;
                    d.done  = 1'b1;
                    d.st    = CSM_DONE;
                end
            end
            CSM_DONE: begin
                d.st = CSM_WAIT;
            end
            // strobes still high after done are the same request; wait for release
            CSM_WAIT: begin
                if (!bus.write && !bus.read) begin
                    d.st = CSM_IDLE;
                end
            end
            default: begin
                d.st = CSM_IDLE;
            end
        endcase
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= '{st: CSM_IDLE, rdata: DATA_RST, done: 1'b0};
        end else begin
            q <= d;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mem_q <= '{default: DATA_RST};
        end else if (do_wr) begin
            mem_q[sp][fn[1:0]][rg[3:0]] <= (cur & ~wmask) | (bus.write_data & wmask);
        end
    end
    assign bus.read_data = q.rdata;
    assign bus.done      = q.done;
endmodule

// ---- core/csm_pkg.sv ----
// Purpose: shared constants and types for the configuration management port
// Assumes: one clock, asynchronous active-high reset
// Notes:   register contents are a small modelled store, not a full config map
package csm_pkg;
    // ****************************************
    // address layout
    // ****************************************
    localparam int ADDR_W       = 19;
    localparam int DATA_W       = 32;
    localparam int BE_W         = 4;
    localparam int SPACE_BIT    = 18;
    localparam int FUNC_HI      = 17;
    localparam int FUNC_LO      = 10;
    localparam int REG_HI       = 9;
    localparam int REG_LO       = 0;
    localparam int FUNC_W       = FUNC_HI - FUNC_LO + 1;
    localparam int REG_W        = REG_HI - REG_LO + 1;
    // ****************************************
    // type-1 header: registers 0x04..0x0f hold bridge fields
    // ****************************************
    localparam logic [REG_W-1:0] T1_REG_FIRST = 10'h004;
    localparam logic [REG_W-1:0] T1_REG_LAST  = 10'h00f;
    // bits that are read-only unless the override is used
    localparam logic [DATA_W-1:0] T1_RO_MASK  = 32'hffff_0000;
    localparam logic [DATA_W-1:0] DATA_RST    = 32'h0000_0000;
    localparam int   RD_LAT     = 1;
endpackage

// ---- core/csm_if.sv ----
// Purpose: carrier between the requester and the management port
// Assumes: both ends on the same clock
// Notes:   no clocking block; the bench connects the modports
`timescale 1ns/1ps
interface csm_if;
    import csm_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic [DATA_W-1:0] write_data;
    logic [BE_W-1:0]   byte_enable;
    logic              read;
    logic [DATA_W-1:0] read_data;
    logic              done;
    logic              type1_readonly_override;
    modport port (
        input  addr, write, write_data, byte_enable, read, type1_readonly_override,
        output read_data, done
    );
    modport req (
        output addr, write, write_data, byte_enable, read, type1_readonly_override,
        input  read_data, done
    );
endinterface

// ---- core/csm_req.sv ----
// Purpose: requester end; turns user commands into one steady request
// Assumes: user issues a command only while ready is high
// Notes:   strobes drop the cycle after done, so back to back needs one idle cycle
`timescale 1ns/1ps
module csm_req
    import csm_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_wdata,
    input  wire logic [BE_W-1:0]   cmd_be,
    input  wire logic              cmd_override,
    output logic                   ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    csm_if.req                     bus
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic              busy;
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [BE_W-1:0]   be;
        logic              ovr;
        logic              ready;
        logic              rsp;
        logic [DATA_W-1:0] data;
    } csm_req_t;
    csm_req_t q, d;
    always_comb begin
        d     = q;
        d.rsp = 1'b0;
        if (!q.busy) begin
            if (cmd_valid && q.ready) begin
                d.busy  = 1'b1;
                d.ready = 1'b0;
                d.wr    = cmd_write;
                d.rd    = !cmd_write;
                d.addr  = cmd_addr;
                d.wdata = cmd_wdata;
                d.be    = cmd_be;
                d.ovr   = cmd_override;
            end
        end else if (bus.done) begin
            // hold everything steady until this pulse
            d.busy  = 1'b0;
            d.wr    = 1'b0;
            d.rd    = 1'b0;
            d.ready = 1'b1;
            d.rsp   = 1'b1;
            d.data  = bus.read_data;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= '{ready: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end
    assign bus.addr                    = q.addr;
    assign bus.write                   = q.wr;
    assign bus.read                    = q.rd;
    assign bus.write_data              = q.wdata;
    assign bus.byte_enable             = q.be;
    assign bus.type1_readonly_override = q.ovr;
    assign ready                       = q.ready;
    assign rsp_valid                   = q.rsp;
    assign rsp_data                    = q.data;
endmodule

// ---- tb/csm_monitor.sv ----
// Purpose: checks on the management carrier
// Assumes: one clock, async high reset
// Notes:   readback trusts only full unprotected writes
`timescale 1ns/1ps
module csm_monitor
    import csm_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              write,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic [BE_W-1:0]   byte_enable,
    input wire logic              read,
    input wire logic [DATA_W-1:0] read_data,
    input wire logic              done,
    input wire logic              type1_readonly_override
);
    typedef struct packed {
        logic              ok;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
    } csm_shadow_t;
    csm_shadow_t      sh_q;
    csm_shadow_t      sh_d;
    logic [REG_W-1:0] rg;
    assign rg = addr[REG_HI:REG_LO];
    always_comb begin
        sh_d = sh_q;
        if (done && write) begin
            sh_d.ok = &byte_enable && (addr[SPACE_BIT] || rg < T1_REG_FIRST || rg > T1_REG_LAST);
            sh_d.a = addr;
            sh_d.d = write_data;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end
    // ****
    // handshake and data
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_done_one_cycle: assert property (done |=> !done)
        else $error("done held too long");
    a_done_after_req: assert property ($rose(write || read) |=> done)
        else $error("done late");
    a_done_has_req: assert property (done |-> $past(write || read))
        else $error("done without request");
    a_rdata_on_read: assert property (!$stable(read_data) |-> done && read)
        else $error("read data moved");
    a_one_strobe: assert property (!(write && read))
        else $error("both strobes");
    a_req_held: assert property ((write || read) && !done |=>
        $stable({addr, write_data, byte_enable, write, read, type1_readonly_override}))
        else $error("request moved");
    a_strobe_drops: assert property (done |=> !(write || read))
        else $error("strobe held after done");
    a_read_back: assert property (done && read && sh_q.ok && addr == sh_q.a |->
        read_data == sh_q.d)
        else $error("readback differs");
endmodule

// ---- tb/config_space_mgmt_port_bench.sv ----
// Purpose: random and corner traffic through requester into port
// Assumes: port in root port mode
// Notes:   endpoint mode is left unexercised
`timescale 1ns/1ps
module config_space_mgmt_port_bench
    import csm_pkg::*;
    ;
    logic              clock = 1'b0;
    logic              rst = 1'b1;
    logic              cv = 1'b0;
    logic              cw = 1'b0;
    logic [ADDR_W-1:0] ca = '0;
    logic [DATA_W-1:0] cd = '0;
    logic [BE_W-1:0]   cb = '0;
    logic              co = 1'b0;
    logic              ready;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic [31:0]       s = 32'hb619_fe6e;
    logic [DATA_W-1:0] mem [128];
    int                err_count = 0;
    int                cmp_count = 0;
    csm_if bus ();
    always #5 clock = ~clock;
    csm_req u_csm_req (.clock(clock), .rst(rst), .cmd_valid(cv), .cmd_write(cw), .cmd_addr(ca),
        .cmd_wdata(cd), .cmd_be(cb), .cmd_override(co), .ready(ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus(bus.req));
    csm_port u_csm_port (.clock(clock), .rst(rst), .bus(bus.port));
    csm_monitor u_csm_monitor (.clock(clock), .rst(rst), .addr(bus.addr), .write(bus.write),
        .write_data(bus.write_data), .byte_enable(bus.byte_enable), .read(bus.read),
        .read_data(bus.read_data), .done(bus.done),
        .type1_readonly_override(bus.type1_readonly_override));
    // model word after a write; protected half kept unless overridden
    function automatic logic [31:0] merge(logic [31:0] o, w, logic [3:0] b, logic v, logic [18:0] a);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        if (!a[18] && a[9:0] >= T1_REG_FIRST && a[9:0] <= T1_REG_LAST && !v) begin
            m &= ~T1_RO_MASK;
        end
        return (o & ~m) | (w & m);
    endfunction
    function automatic logic [31:0] xorshift(logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        y = y ^ (y << 5);
        return y;
    endfunction
    task automatic chk(logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic op(logic w, logic [18:0] a, logic [31:0] d, logic [3:0] b, logic v);
        int          n;
        logic [6:0]  i;
        i = {a[18], a[11:10], a[3:0]};
        @(posedge clock);
        cv <= 1'b1;
        cw <= w;
        ca <= a;
        cd <= d;
        cb <= b;
        co <= v;
        @(posedge clock);
        cv <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
            if (n == 1) begin
                chk({31'h0000_0000, ready}, 32'h0000_0000);
            end
        end while (rsp_valid !== 1'b1 && n < 8);
        if (rsp_valid !== 1'b1) begin
            err_count++;
            close_out();
        end else begin
            chk({31'h0000_0000, ready}, 32'h0000_0001);
            if (w) begin
                mem[i] = merge(mem[i], d, b, v, a);
            end else begin
                chk(rsp_data, mem[i]);
            end
        end
    endtask
    logic [18:0] corner [4] = '{19'h0_0003, 19'h0_0004, 19'h0_000f, 19'h4_0004};
    initial begin
        foreach (mem[k]) mem[k] = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        for (int j = 0; j < 8; j++) begin
            op(1'b1, corner[j%4], 32'hffff_ffff, 4'hf, j > 3);
            op(1'b0, corner[j%4], '0, '0, 1'b0);
        end
        repeat (300) begin
            s = xorshift(s);
            op(s[0], {s[1], 6'h00, s[3:2], 6'h00, s[7:4]}, {s[15:0], s[31:16]}, s[11:8], s[12]);
        end
        close_out();
    end
endmodule
